// *** src/smswc_defs.vh ***
// constants for the switch monitor sleep and wake controller
`ifndef SMSWC_DEFS_VH
`define SMSWC_DEFS_VH
`define SMSWC_FRAME_BITS 24
`define SMSWC_CMD_STATUS 8'h00
`define SMSWC_CMD_SETTINGS 8'h01
`define SMSWC_CMD_WAKE_SP 8'h02
`define SMSWC_CMD_WAKE_SG 8'h03
`define SMSWC_CMD_METAL_SP 8'h04
`define SMSWC_CMD_METAL_SG 8'h05
`define SMSWC_CMD_TIMER_SP 8'h07
`define SMSWC_CMD_TIMER_SG 8'h08
`define SMSWC_CMD_TRI_SP 8'h09
`define SMSWC_CMD_TRI_SG 8'h0a
`define SMSWC_CMD_SLEEP 8'h0c
`define SMSWC_CMD_RESET 8'h7f
`define SMSWC_SO_THERM_BIT 23
`define SMSWC_SO_INT_BIT 22
`define SMSWC_INT_MSB 5
`define SMSWC_INT_LSB 3
`define SMSWC_SCAN_MSB 2
`define SMSWC_SCAN_LSB 0
`define SMSWC_INT_OFF 3'h7
`define SMSWC_SCAN_OFF 3'h0
`define SMSWC_CLK_HZ 10000000
`define SMSWC_WET_MS 20
`define SMSWC_INT_BASE_MS 32
`define SMSWC_SCAN_BASE_US 1000
`define SMSWC_SCAN_WIN_US 125
`define SMSWC_WET_CYC (`SMSWC_WET_MS * (`SMSWC_CLK_HZ / 1000))
`define SMSWC_INT_BASE_CYC (`SMSWC_INT_BASE_MS * (`SMSWC_CLK_HZ / 1000))
`define SMSWC_SCAN_BASE_CYC (`SMSWC_SCAN_BASE_US * (`SMSWC_CLK_HZ / 1000000))
`define SMSWC_SCAN_WIN_CYC (`SMSWC_SCAN_WIN_US * (`SMSWC_CLK_HZ / 1000000))
`endif

// *** src/smswc_sync.v ***
// three-stage synchroniser for a bus of pin inputs, change on stage agreement
`timescale 1ns/1ps
`default_nettype none
module smswc_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   input wire ref_clk_i,
   input wire reset_i,
   input wire ce_i,
   input wire [WIDTH-1:0] d_i,
   output reg [WIDTH-1:0] q_o
);
   reg [WIDTH-1:0] s1_reg;
   reg [WIDTH-1:0] s2_reg;
   reg [WIDTH-1:0] s3_reg;
   genvar i;
   always @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         s1_reg <= INIT;
         s2_reg <= INIT;
         s3_reg <= INIT;
      end else if (ce_i) begin
         s1_reg <= d_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end
   // output follows only once stages two and three agree, per bit
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge ref_clk_i or posedge reset_i) begin
            if (reset_i) begin
               q_o[i] <= INIT[i];
            end else if (ce_i && (s2_reg[i] == s3_reg[i])) begin
               q_o[i] <= s3_reg[i];
            end
         end
      end
   endgenerate
endmodule // smswc_sync
`default_nettype wire

// *** src/smswc_ctrl.v ***
// mode, wake, timer, thermal and wetting control of the switch monitor
// Summary of operation
// [R1] switch change holds interrupt low until host reads status
// [R2] closure during low chip select keeps interrupt past the rising edge
// [R3] change raises interrupt and gives high wetting current for 20 ms
// [R4] sleep is entered only by a valid sleep command
// [R5] all configuration survives sleep unchanged
// [R6] wake on input change, timer, wake pin, int, chip select, reset
// [R7] without logic supply, int and chip select edges do not wake
// [R8] host discards serial output of a chip-select wake transfer
// [R9] sleep command: interrupt timer bits 5..3, scan timer bits 2..0
// [R10] interrupt timer expiry asserts interrupt and returns to normal
// [R11] interrupt period 32 ms doubling to 2.048 s, code 111 off
// [R12] scan period none, 1 ms doubling to 64 ms
// [R13] scan expiry enables inputs 125 us, then compares with stored states
// [R14] changed scan state interrupts if enabled and returns to normal
// [R15] unchanged scan restarts timer, tri-states inputs, stays asleep
// [R16] both sleep timers idle in normal mode
// [R17] thermal supervision only in normal mode
// [R18] over limit: interrupt, thermal flag, derate high current to low
// [R19] thermal flag clears at chip select rise only once cooled
// [R20] after cooling, programmed currents are restored
// [R21] metallic inputs get high current only for 20 ms after closure
// [R22] with wetting timer off, current is continuous while closed
// [R23] serial word: thermal flag bit 23, interrupt flag bit 22, states
// [R24] 24-bit frames, command in upper byte, act at chip select rise
`timescale 1ns/1ps
`default_nettype none
`include "smswc_defs.vh"
module smswc_ctrl #(
   parameter NSW = 22,
   parameter NSP = 8,
   parameter WET_CYC = `SMSWC_WET_CYC,
   parameter INT_BASE_CYC = `SMSWC_INT_BASE_CYC,
   parameter SCAN_BASE_CYC = `SMSWC_SCAN_BASE_CYC,
   parameter SCAN_WIN_CYC = `SMSWC_SCAN_WIN_CYC
) (
   input wire ref_clk_i,
   input wire reset_i,
   input wire ce_i,
   input wire cs_n_i,
   input wire sclk_i,
   input wire si_i,
   output reg so_o,
   output wire int_n_o,
   output wire int_n_oe_n_o,
   input wire int_n_i,
   input wire wake_n_i,
   input wire vdd_ok_i,
   input wire over_temp_i,
   input wire [NSW-1:0] switch_closed_i,
   output reg sleep_o,
   output reg [NSW-1:0] input_enable_o,
   output reg [NSW-1:0] high_current_o,
   output reg [NSW-1:0] low_current_o,
   output reg [NSP-1:0] sp_to_battery_o,
   output reg thermal_flag_o
);
   localparam ST_NORMAL = 3'b001;
   localparam ST_SLEEP = 3'b010;
   localparam ST_SCAN = 3'b100;
   localparam CW = 32;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   wire [NSW+6:0] raw_w = {over_temp_i, vdd_ok_i, wake_n_i, int_n_i,
                           si_i, sclk_i, cs_n_i, switch_closed_i};
   wire [NSW+6:0] syn_w;
   smswc_sync #(.WIDTH(NSW+7), .INIT({4'h7, 3'h1, {NSW{1'b0}}})) u_sync (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .d_i(raw_w),
      .q_o(syn_w)
   );
   wire [NSW-1:0] sw_w = syn_w[NSW-1:0];
   wire cs_n_w = syn_w[NSW];
   wire sclk_w = syn_w[NSW+1];
   wire si_w = syn_w[NSW+2];
   wire int_line_w = syn_w[NSW+3];
   wire wake_w = syn_w[NSW+4];
   wire vdd_w = syn_w[NSW+5];
   wire hot_w = syn_w[NSW+6];

   reg cs_d_reg, sclk_d_reg, intl_d_reg, wake_d_reg;
   wire cs_fall_w = cs_d_reg & ~cs_n_w;
   wire cs_rise_w = ~cs_d_reg & cs_n_w;
   wire sclk_rise_w = ~sclk_d_reg & sclk_w;
   wire sclk_fall_w = sclk_d_reg & ~sclk_w;

   // ----------------------------------------------------------------
   // configuration and state
   // ----------------------------------------------------------------
   reg [2:0] state_reg;
   reg [23:0] sh_in_reg;
   reg [23:0] sh_out_reg;
   reg [5:0] bit_cnt_reg;
   reg int_pend_reg;
   reg cs_closure_reg;
   reg [NSW-1:0] last_sw_reg;
   reg [NSW-1:0] wake_en_reg, metal_reg, timer_en_reg, tri_reg;
   reg [2:0] int_sel_reg, scan_sel_reg;
   reg [CW-1:0] int_cnt_reg, scan_cnt_reg;
   reg [NSW*CW-1:0] wet_cnt_reg;
   wire [7:0] cmd_w = sh_in_reg[23:16];
   wire frame_ok_w = (bit_cnt_reg == `SMSWC_FRAME_BITS);
   wire [CW-1:0] int_period_w = INT_BASE_CYC << int_sel_reg; // [R11]
   wire [CW-1:0] scan_period_w = SCAN_BASE_CYC << (scan_sel_reg - 3'h1); // [R12]
   wire [NSW-1:0] change_w = sw_w ^ last_sw_reg;
   wire sw_change_w = |(change_w & ~tri_reg);
   wire int_exp_w = (int_sel_reg != `SMSWC_INT_OFF) &&
                    (int_cnt_reg >= int_period_w - 1);
   wire wake_evt_w = (wake_d_reg & ~wake_w) | // [R6]
                     (vdd_w & wake_w & intl_d_reg & ~int_line_w) | // [R7]
                     (vdd_w & cs_fall_w); // [R7]
   // in sleep our own driver is off, so a low on the line is from another device
   assign int_n_o = 1'b0;
   assign int_n_oe_n_o = ~(int_pend_reg & (state_reg == ST_NORMAL)); // [R1]

   // ----------------------------------------------------------------
   // main sequencing
   // ----------------------------------------------------------------
   always @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg <= ST_NORMAL;
         cs_d_reg <= 1'b1;
         sclk_d_reg <= 1'b0;
         intl_d_reg <= 1'b1;
         wake_d_reg <= 1'b1;
         sh_in_reg <= 24'h000000;
         sh_out_reg <= 24'h000000;
         bit_cnt_reg <= 6'h00;
         so_o <= 1'b0;
         int_pend_reg <= 1'b0;
         cs_closure_reg <= 1'b0;
         last_sw_reg <= {NSW{1'b0}};
         wake_en_reg <= {NSW{1'b1}};
         metal_reg <= {NSW{1'b1}};
         timer_en_reg <= {NSW{1'b1}};
         tri_reg <= {NSW{1'b1}};
         sp_to_battery_o <= {NSP{1'b1}};
         int_sel_reg <= 3'h0;
         scan_sel_reg <= 3'h0;
         int_cnt_reg <= {CW{1'b0}};
         scan_cnt_reg <= {CW{1'b0}};
         thermal_flag_o <= 1'b0;
         sleep_o <= 1'b0;
         input_enable_o <= {NSW{1'b0}};
      end else if (ce_i) begin
         cs_d_reg <= cs_n_w;
         sclk_d_reg <= sclk_w;
         intl_d_reg <= int_line_w;
         wake_d_reg <= wake_w;
         sleep_o <= (state_reg != ST_NORMAL);
         input_enable_o <= (state_reg == ST_SLEEP) ? {NSW{1'b0}} : ~tri_reg; // [R15]
         case (state_reg)
            ST_NORMAL: begin
               int_cnt_reg <= {CW{1'b0}}; // [R16]
               scan_cnt_reg <= {CW{1'b0}}; // [R16]
               last_sw_reg <= sw_w;
               if (sw_change_w && ~cs_n_w) begin
                  cs_closure_reg <= 1'b1; // [R2]
               end
               if (hot_w) begin
                  thermal_flag_o <= 1'b1; // [R17] [R18]
               end else if (cs_rise_w) begin
                  thermal_flag_o <= 1'b0; // [R19]
               end
               // spi framing: sample on clock rise, shift out on fall
               if (cs_fall_w) begin
                  bit_cnt_reg <= 6'h00;
                  sh_out_reg <= {thermal_flag_o, int_pend_reg,
                                 sw_w[NSW-1:0]}; // [R23]
                  so_o <= thermal_flag_o;
               end else if (~cs_n_w && sclk_rise_w) begin
                  sh_in_reg <= {sh_in_reg[22:0], si_w};
                  if (bit_cnt_reg != 6'h3f) begin
                     bit_cnt_reg <= bit_cnt_reg + 6'h01;
                  end
               end else if (~cs_n_w && sclk_fall_w) begin
                  sh_out_reg <= {sh_out_reg[22:0], 1'b0};
                  so_o <= sh_out_reg[22];
               end
               if ((sw_change_w && (|(change_w & wake_en_reg))) ||
                   (hot_w && ~thermal_flag_o)) begin
                  int_pend_reg <= 1'b1; // [R3] [R18]
               end else if (cs_rise_w && frame_ok_w && ~cs_closure_reg) begin
                  int_pend_reg <= 1'b0; // [R1]
               end
               if (cs_rise_w) begin
                  cs_closure_reg <= 1'b0;
               end
               if (cs_rise_w && frame_ok_w) begin // [R24]
                  case (cmd_w)
                     `SMSWC_CMD_SETTINGS: sp_to_battery_o <= sh_in_reg[NSP-1:0];
                     `SMSWC_CMD_WAKE_SP: wake_en_reg[NSW-1:NSW-NSP] <= sh_in_reg[NSP-1:0];
                     `SMSWC_CMD_WAKE_SG: wake_en_reg[NSW-NSP-1:0] <= sh_in_reg[NSW-NSP-1:0];
                     `SMSWC_CMD_METAL_SP: metal_reg[NSW-1:NSW-NSP] <= sh_in_reg[NSP-1:0];
                     `SMSWC_CMD_METAL_SG: metal_reg[NSW-NSP-1:0] <= sh_in_reg[NSW-NSP-1:0];
                     `SMSWC_CMD_TIMER_SP: timer_en_reg[NSW-1:NSW-NSP] <= sh_in_reg[NSP-1:0];
                     `SMSWC_CMD_TIMER_SG: timer_en_reg[NSW-NSP-1:0] <= sh_in_reg[NSW-NSP-1:0];
                     `SMSWC_CMD_TRI_SP: tri_reg[NSW-1:NSW-NSP] <= sh_in_reg[NSP-1:0];
                     `SMSWC_CMD_TRI_SG: tri_reg[NSW-NSP-1:0] <= sh_in_reg[NSW-NSP-1:0];
                     `SMSWC_CMD_SLEEP: begin
                        int_sel_reg <= sh_in_reg[`SMSWC_INT_MSB:`SMSWC_INT_LSB]; // [R9]
                        scan_sel_reg <= sh_in_reg[`SMSWC_SCAN_MSB:`SMSWC_SCAN_LSB]; // [R9]
                        state_reg <= ST_SLEEP; // [R4] [R5]
                     end
                     `SMSWC_CMD_RESET: begin
                        wake_en_reg <= {NSW{1'b1}};
                        metal_reg <= {NSW{1'b1}};
                        timer_en_reg <= {NSW{1'b1}};
                        tri_reg <= {NSW{1'b1}};
                        sp_to_battery_o <= {NSP{1'b1}};
                     end
                     default: ;
                  endcase
               end
            end
            ST_SLEEP: begin
               int_cnt_reg <= int_cnt_reg + 32'h1;
               if (scan_sel_reg != `SMSWC_SCAN_OFF) begin
                  scan_cnt_reg <= scan_cnt_reg + 32'h1;
               end
               if (int_exp_w) begin
                  int_pend_reg <= 1'b1; // [R10]
                  state_reg <= ST_NORMAL;
               end else if (wake_evt_w) begin
                  state_reg <= ST_NORMAL; // [R6] [R8]
               end else if ((scan_sel_reg != `SMSWC_SCAN_OFF) &&
                            (scan_cnt_reg >= scan_period_w - 1)) begin
                  scan_cnt_reg <= {CW{1'b0}};
                  state_reg <= ST_SCAN; // [R13]
               end
            end
            ST_SCAN: begin
               int_cnt_reg <= int_cnt_reg + 32'h1;
               scan_cnt_reg <= scan_cnt_reg + 32'h1;
               if (scan_cnt_reg >= SCAN_WIN_CYC - 1) begin
                  scan_cnt_reg <= {CW{1'b0}};
                  if (sw_change_w) begin // [R13]
                     if (|(change_w & wake_en_reg)) begin
                        int_pend_reg <= 1'b1; // [R14]
                     end
                     state_reg <= ST_NORMAL; // [R14]
                  end else begin
                     state_reg <= ST_SLEEP; // [R15]
                  end
               end
            end
            default: state_reg <= ST_NORMAL;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // per-input wetting current timers
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NSW; g = g + 1) begin : g_wet
         wire [CW-1:0] cnt_w = wet_cnt_reg[g*CW +: CW];
         wire timing_w = (cnt_w < WET_CYC);
         always @(posedge ref_clk_i or posedge reset_i) begin
            if (reset_i) begin
               wet_cnt_reg[g*CW +: CW] <= {CW{1'b0}};
               high_current_o[g] <= 1'b0;
               low_current_o[g] <= 1'b0;
            end else if (ce_i) begin
               if (state_reg != ST_NORMAL || sw_w[g] != last_sw_reg[g]) begin
                  wet_cnt_reg[g*CW +: CW] <= {CW{1'b0}}; // [R3] [R21]
               end else if (timing_w) begin
                  wet_cnt_reg[g*CW +: CW] <= cnt_w + 32'h1;
               end
               if (tri_reg[g] || state_reg == ST_SLEEP) begin
                  high_current_o[g] <= 1'b0;
                  low_current_o[g] <= 1'b0;
               end else if (metal_reg[g] && sw_w[g] &&
                            (timing_w || ~timer_en_reg[g])) begin // [R21] [R22]
                  high_current_o[g] <= ~hot_w; // [R18] [R20]
                  low_current_o[g] <= hot_w; // [R18]
               end else begin
                  high_current_o[g] <= 1'b0;
                  low_current_o[g] <= 1'b1;
               end
            end
         end
      end
   endgenerate
endmodule // smswc_ctrl
`default_nettype wire

// *** dv/smswc_host_model.sv ***
// host side model: spi master sending 24-bit frames to the controller
`timescale 1ns/1ps
`default_nettype none
module smswc_host_model (
   input wire logic ref_clk_i,
   input wire logic go_i,
   input wire logic [23:0] word_i,
   input wire logic so_i,
   output logic cs_n_o,
   output logic sclk_o,
   output logic si_o,
   output logic busy_o,
   output logic [23:0] so_word_o
);
   // six ref cycles per sclk phase, the controller needs at least five
   task automatic half();
      repeat (6) @(negedge ref_clk_i);
   endtask
   initial begin
      cs_n_o = 1'h1;
      sclk_o = 1'h0;
      si_o = 1'h0;
      busy_o = 1'h0;
      so_word_o = 24'h000000;
      forever begin
         @(posedge ref_clk_i);
         if (go_i) begin
            busy_o = 1'h1;
            @(negedge ref_clk_i);
            cs_n_o = 1'h0;
            for (int i = 23; i >= 0; i--) begin
               si_o = word_i[i];
               half();
               sclk_o = 1'h1;
               so_word_o[i] = so_i;
               half();
               sclk_o = 1'h0;
            end
            half();
            cs_n_o = 1'h1;
            // deselected data line must not keep the last bit
            si_o = ~si_o;
            repeat (10) @(negedge ref_clk_i);
            busy_o = 1'h0;
         end
      end
   end
endmodule // smswc_host_model
`default_nettype wire

// *** dv/smswc_ctrl_properties.sv ***
// concurrent checks on the switch monitor controller ports
`timescale 1ns/1ps
`default_nettype none
module smswc_ctrl_properties #(
   parameter NSW = 22
) (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic cs_n_i,
   input wire logic wake_n_i,
   input wire logic over_temp_i,
   input wire logic int_n_oe_n_o,
   input wire logic sleep_o,
   input wire logic [NSW-1:0] input_enable_o,
   input wire logic [NSW-1:0] high_current_o,
   input wire logic thermal_flag_o
);
   default clocking dc @(posedge ref_clk_i);
   endclocking
   default disable iff (reset_i);
   a_sleep_entry: assert property ($rose(sleep_o) |-> cs_n_i)
      else $error("sleep entered while chip select low");
   a_int_release: assert property ($rose(int_n_oe_n_o) |-> cs_n_i)
      else $error("interrupt released without a frame end");
   a_flag_clear: assert property ($fell(thermal_flag_o) |-> cs_n_i)
      else $error("thermal flag cleared while chip select low");
   a_flag_hot_hold: assert property (thermal_flag_o && over_temp_i &&
      $past(over_temp_i, 8) |=> thermal_flag_o)
      else $error("thermal flag cleared while still hot");
   a_derate_high: assert property (over_temp_i && $past(over_temp_i, 8) &&
      !sleep_o && !$past(sleep_o, 8) |-> ~|high_current_o)
      else $error("high current kept while over temperature");
   a_thermal_normal: assert property ($rose(thermal_flag_o) |->
      !sleep_o)
      else $error("thermal flag set from sleep");
   a_wake_pin: assert property (sleep_o && ~|input_enable_o &&
      $fell(wake_n_i) |-> ##[1:12] !sleep_o)
      else $error("wake pin fall did not leave sleep");
   a_scan_window: assert property (sleep_o && $rose(|input_enable_o)
      |-> (|input_enable_o) [*4])
      else $error("scan window shorter than programmed");
endmodule // smswc_ctrl_properties
bind smswc_ctrl smswc_ctrl_properties #(.NSW(NSW)) u_props (
   .ref_clk_i(ref_clk_i), .reset_i(reset_i), .cs_n_i(cs_n_i),
   .wake_n_i(wake_n_i), .over_temp_i(over_temp_i),
   .int_n_oe_n_o(int_n_oe_n_o), .sleep_o(sleep_o),
   .input_enable_o(input_enable_o), .high_current_o(high_current_o),
   .thermal_flag_o(thermal_flag_o));
`default_nettype wire

// *** dv/smswc_ctrl_tb_top.sv ***
// self-checking bench for the switch monitor sleep and wake controller
`timescale 1ns/1ps
`default_nettype none
module smswc_ctrl_tb_top;
   logic clk, rst, go, wake_n, vdd, hot, host_int_n;
   logic [21:0] sw;
   logic [23:0] word;
   wire cs_n, sclk, si, so, int_n, int_oe_n, sleep, flag, busy;
   wire [21:0] en, hi, lo;
   wire [7:0] spb;
   wire [23:0] sow;
   wire int_line;
   int fail_count = 0;
   int n_compared = 0;
   // open-drain line, either side may pull it low
   assign int_line = (int_oe_n ? 1'h1 : int_n) & host_int_n;
   smswc_ctrl #(.WET_CYC(50), .INT_BASE_CYC(40), .SCAN_BASE_CYC(20),
      .SCAN_WIN_CYC(5)) u_dut (
      .ref_clk_i(clk), .reset_i(rst), .ce_i(1'h1), .cs_n_i(cs_n),
      .sclk_i(sclk), .si_i(si), .so_o(so), .int_n_o(int_n),
      .int_n_oe_n_o(int_oe_n), .int_n_i(int_line), .wake_n_i(wake_n),
      .vdd_ok_i(vdd), .over_temp_i(hot), .switch_closed_i(sw),
      .sleep_o(sleep), .input_enable_o(en), .high_current_o(hi),
      .low_current_o(lo), .sp_to_battery_o(spb), .thermal_flag_o(flag));
   smswc_host_model u_host (.ref_clk_i(clk), .go_i(go), .word_i(word),
      .so_i(so), .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si), .busy_o(busy),
      .so_word_o(sow));
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input string nm, input logic [23:0] e,
      input logic [23:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic frame(input logic [23:0] w);
      word = w;
      go = 1'h1;
      cyc(1);
      go = 1'h0;
      while (busy) cyc(1);
   endtask
   function automatic logic [23:0] slp(input logic [2:0] it,
      input logic [2:0] sc);
      return {8'h0c, 10'h000, it, sc};
   endfunction
   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_change;
      chk("spb reset", 8'hff, spb);
      frame(24'h090000);
      frame(24'h0a0000);
      sw[0] = 1'h1;
      cyc(15);
      chk("int on change", 1'h0, int_oe_n);
      chk("wet on", 1'h1, hi[0]);
      cyc(60);
      chk("wet timed out", 1'h0, hi[0]);
      chk("int held", 1'h0, int_oe_n);
      fork
         frame(24'h000000);
         begin
            cyc(100);
            sw[3] = 1'h1;
         end
      join
      chk("so int flag", 1'h1, sow[22]);
      chk("so state", 1'h1, sow[0]);
      chk("int kept", 1'h0, int_oe_n);
      frame(24'h000000);
      chk("int cleared", 1'h1, int_oe_n);
      $display("test change done");
   endtask
   task automatic t_timer_off;
      frame(24'h083ffd);
      sw[1] = 1'h1;
      cyc(80);
      chk("wet continuous", 1'h1, hi[1]);
      frame(24'h000000);
      $display("test timer off done");
   endtask
   task automatic t_thermal;
      hot = 1'h1;
      cyc(15);
      chk("flag set", 1'h1, flag);
      chk("int hot", 1'h0, int_oe_n);
      chk("derated", 22'h000000, hi);
      chk("low current", 1'h1, lo[1]);
      frame(24'h000000);
      chk("so therm", 1'h1, sow[23]);
      chk("flag kept", 1'h1, flag);
      hot = 1'h0;
      cyc(15);
      chk("restored", 1'h1, hi[1]);
      frame(24'h000000);
      chk("flag cleared", 1'h0, flag);
      $display("test thermal done");
   endtask
   task automatic t_sleep_keep;
      frame(24'h0100a5);
      chk("spb set", 8'ha5, spb);
      frame(slp(3'h7, 3'h0));
      chk("asleep", 1'h1, sleep);
      hot = 1'h1;
      cyc(3000);
      chk("no timer wake", 1'h1, sleep);
      chk("no flag asleep", 1'h0, flag);
      hot = 1'h0;
      cyc(15);
      wake_n = 1'h0;
      cyc(15);
      chk("pin wake", 1'h0, sleep);
      wake_n = 1'h1;
      frame(24'h000000);
      chk("spb kept", 8'ha5, spb);
      chk("timer off kept", 1'h1, hi[1]);
      $display("test sleep keep done");
   endtask
   task automatic t_int_timer;
      for (int c = 0; c < 3; c++) begin
         frame(slp(c[2:0], 3'h0));
         cyc((40 << c) - 15);
         chk("before expiry", 1'h1, sleep);
         cyc(25);
         chk("timer wake", 1'h0, sleep);
         chk("timer int", 1'h0, int_oe_n);
         frame(24'h000000);
      end
      $display("test interrupt timer done");
   endtask
   task automatic t_scan;
      int n;
      logic p;
      n = 0;
      p = 1'h0;
      frame(slp(3'h7, 3'h1));
      repeat (200) begin
         cyc(1);
         if (en[2] && !p) n++;
         p = en[2];
      end
      chk("scan count", 1'h1, n >= 5 && n <= 11);
      chk("stays asleep", 1'h1, sleep);
      sw[2] = 1'h1;
      cyc(80);
      chk("scan wake", 1'h0, sleep);
      chk("scan int", 1'h0, int_oe_n);
      frame(24'h000000);
      $display("test scan done");
   endtask
   task automatic t_supply;
      frame(slp(3'h7, 3'h0));
      vdd = 1'h0;
      host_int_n = 1'h0;
      cyc(10);
      host_int_n = 1'h1;
      frame(24'h000000);
      chk("no supply", 1'h1, sleep);
      vdd = 1'h1;
      cyc(10);
      // reply of a waking transfer is not used
      frame(24'h000000);
      chk("cs wake", 1'h0, sleep);
      frame(slp(3'h7, 3'h0));
      host_int_n = 1'h0;
      cyc(15);
      host_int_n = 1'h1;
      chk("int line wake", 1'h0, sleep);
      frame(24'h000000);
      frame(24'h7f0000);
      chk("spb reset cmd", 8'hff, spb);
      $display("test supply done");
   endtask
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   initial begin
      rst = 1'h1;
      go = 1'h0;
      wake_n = 1'h1;
      vdd = 1'h1;
      hot = 1'h0;
      host_int_n = 1'h1;
      sw = 22'h000000;
      word = 24'h000000;
      cyc(6);
      rst = 1'h0;
      cyc(10);
      t_change();
      t_timer_off();
      t_thermal();
      t_sleep_keep();
      t_int_timer();
      t_scan();
      t_supply();
      give_verdict();
   end
   // the whole sequence needs well under half of this
   initial begin
      cyc(40000);
      fail_count++;
      give_verdict();
   end
endmodule // smswc_ctrl_tb_top
`default_nettype wire
